// [core/mfg_gpio.sv]
/*
  multi-function pin block: per-pin input, output, loss-of-lock, alert
  and output-disable functions, with axi4-lite register access.
  assumes alarm sources and lock status are on ref_clk; pin inputs are
  asynchronous and resync here; resetDone comes from the reset sequencer.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mfg_params.svh"

module mfg_gpio #(
  parameter int NPIN = 9,
  parameter int NALM = 8,
  parameter int NCLK = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              resetDone,
  input  wire logic              lockLost,
  input  wire logic [NALM-1:0]   alarmEvt,
  input  wire logic [NPIN-1:0]   pinIn,
  output logic      [NPIN-1:0]   pinOut,
  output logic      [NPIN-1:0]   pinOe_n,
  output logic      [NPIN-1:0]   pinPullUp,
  output logic      [NPIN-1:0]   pinPullDn,
  output logic      [NCLK-1:0]   clkOutDisable,
  output logic      [NCLK-1:0]   clkOutHiZ,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int NSTK = NALM + 1;

  logic [31:0]     pinCfg_r  [NPIN];
  logic [NCLK-1:0] clkMask_r [NPIN];
  logic [NSTK-1:0] alrEn_r   [NPIN];
  logic            v18_r;
  logic [NPIN-1:0] outLvl_r;
  logic [NSTK-1:0] sticky_r;
  logic [NPIN-1:0] pinSync1_r, pinSync2_r;
  logic [NPIN-1:0] inLvl_r;
  logic            done_r;
  logic [NPIN-1:0] fnOut;
  logic [NPIN-1:0] drvEn;
  logic [NCLK-1:0] disReq;
  logic [NCLK-1:0] clkDis_r;
  logic [NCLK-1:0] clkHiZ_r;

  // axi write and read channel latches, strobes and read decode
  logic [7:0]  awAddr_r;
  logic        awHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHeld_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic        wrFire;
  logic [NSTK-1:0] stkClr;
  logic [7:0]      rdAddr;
  logic [31:0]     rdWord;
  logic            rdOk;

  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  st);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : strbMerge

  function automatic mfg_pkg::mfg_mode_t cfgMode(input logic [31:0] c);
    return mfg_pkg::mfg_mode_t'(c[`MFG_CFG_MODE_LO +: `MFG_CFG_MODE_W]);
  endfunction : cfgMode

  // pin-array slot decode: base offset, window of four bytes per pin
  function automatic logic inWin(input logic [7:0] a, input logic [7:0] base,
                                 input int n);
    return (a >= base) && (a < base + 8'(n * 4));
  endfunction : inWin

  // one word per pin, laid out upward from a base offset
  function automatic logic slotHit(input logic [7:0] a,
                                   input logic [7:0] base, input int p);
    return a == base + 8'(p * 4);
  endfunction : slotHit

  // registers are whole words: the two low address bits are ignored
  function automatic logic [7:0] wordAddr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction : wordAddr

  // pin inputs are asynchronous: two flops before anything reads them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1_r <= '0;
      pinSync2_r <= '0;
    end else if (clkEn) begin
      pinSync1_r <= pinIn;
      pinSync2_r <= pinSync1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
    end else if (clkEn) begin
      done_r <= resetDone;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inLvl_r <= '0;
    end else if (clkEn) begin
      inLvl_r <= pinSync2_r;
    end
  end

  assign wrFire = awHeld_r && wHeld_r && !bValid_r;

  // clear strobe: byte lane 0 gates every clear bit
  always_comb begin
    stkClr = '0;
    if (wrFire && awAddr_r == `MFG_OFS_STICKY) begin
      stkClr = wData_r[NSTK-1:0] & {NSTK{wStrb_r[0]}};
    end
  end

  // sticky status: hardware set beats a same-cycle software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_r <= '0;
    end else if (clkEn) begin
      // no self-release: only a written one clears; a source still active
      // sets its bit again at once, so software cannot lose an alarm
      sticky_r <= (sticky_r & ~stkClr) | {alarmEvt, lockLost};
    end
  end

  // global flag and output levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      v18_r    <= 1'b0;
      outLvl_r <= '0;
    end else if (clkEn && wrFire) begin
      if (awAddr_r == `MFG_OFS_GLOBAL && wStrb_r[0]) begin
        v18_r <= wData_r[`MFG_GLB_V18];
      end
      if (awAddr_r == `MFG_OFS_OUTLVL) begin
        outLvl_r <= NPIN'(strbMerge(32'(outLvl_r), wData_r, wStrb_r));
      end
    end
  end

  // per-pin configuration, clock masks and alert enables
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NPIN; p++) begin
        pinCfg_r[p]  <= `MFG_CFG_RST;
        clkMask_r[p] <= '0;
        alrEn_r[p]   <= '0;
      end
    end else if (clkEn && wrFire) begin
      for (int p = 0; p < NPIN; p++) begin
        if (slotHit(awAddr_r, `MFG_OFS_PINBASE, p)) begin
          pinCfg_r[p] <= strbMerge(pinCfg_r[p], wData_r, wStrb_r);
        end
        if (slotHit(awAddr_r, `MFG_OFS_MASKBASE, p)) begin
          clkMask_r[p] <= NCLK'(strbMerge(32'(clkMask_r[p]), wData_r,
                                          wStrb_r));
        end
        if (slotHit(awAddr_r, `MFG_OFS_ALRBASE, p)) begin
          alrEn_r[p] <= NSTK'(strbMerge(32'(alrEn_r[p]), wData_r, wStrb_r));
        end
      end
    end
  end

  // per-pin function and drive; each pin built from shared sources
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : gPin
      mfg_pkg::mfg_mode_t md;
      logic en, od, isOut;
      assign md = cfgMode(pinCfg_r[g]);
      assign en = pinCfg_r[g][`MFG_CFG_EN] && done_r;
      assign od = pinCfg_r[g][`MFG_CFG_OD];
      always_comb begin
        isOut = 1'b1;
        case (md)
          mfg_pkg::MFG_MODE_OUT:   fnOut[g] = outLvl_r[g];
          mfg_pkg::MFG_MODE_LOL:   fnOut[g] = sticky_r[`MFG_STK_LOL];
          // only latched bits reach the alert OR
          mfg_pkg::MFG_MODE_ALERT: fnOut[g] = |(sticky_r & alrEn_r[g]);
          default: begin
            fnOut[g] = 1'b0;
            isOut    = 1'b0;
          end
        endcase
        // open drain never drives a high: the pull-up has to lift the pin
        drvEn[g] = en && isOut && !(od && fnOut[g]);
      end
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pinOut[g]    <= 1'b0;
          pinOe_n[g]   <= 1'b1;
          pinPullUp[g] <= 1'b1;
          pinPullDn[g] <= 1'b0;
        end else if (clkEn) begin
          pinOut[g]    <= fnOut[g];
          pinOe_n[g]   <= !drvEn[g];
          pinPullUp[g] <= pinCfg_r[g][`MFG_CFG_PULLUP];
          pinPullDn[g] <= !pinCfg_r[g][`MFG_CFG_PULLUP];
        end
      end
    end
  endgenerate

  always_comb begin
    disReq = '0;
    for (int p = 0; p < NPIN; p++) begin
      if (done_r && pinCfg_r[p][`MFG_CFG_EN] &&
          cfgMode(pinCfg_r[p]) == mfg_pkg::MFG_MODE_ODIS &&
          pinSync2_r[p]) begin
        disReq = disReq | clkMask_r[p];
      end
    end
  end

  // disable first, tri-state a cycle later; release hi-z before enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkDis_r <= '0;
      clkHiZ_r <= '0;
    end else if (clkEn) begin
      clkDis_r <= disReq | clkHiZ_r;
      clkHiZ_r <= disReq & clkDis_r;
    end
  end
  assign clkOutDisable = clkDis_r;
  assign clkOutHiZ     = clkHiZ_r;

  // axi4-lite write side: address and data accepted in either order
  // a new pair may be latched while a response waits; it fires after bready
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r  <= 1'b0;
      wData_r  <= '0;
      wStrb_r  <= '0;
      bValid_r <= 1'b0;
      bResp_r  <= `MFG_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= wordAddr(s_axi_awaddr);
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r  <= wrOk(awAddr_r) ? `MFG_RESP_OKAY : `MFG_RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  function automatic logic wrOk(input logic [7:0] a);
    return a == `MFG_OFS_GLOBAL || a == `MFG_OFS_STICKY ||
           a == `MFG_OFS_OUTLVL || inWin(a, `MFG_OFS_PINBASE, NPIN) ||
           inWin(a, `MFG_OFS_MASKBASE, NPIN) ||
           inWin(a, `MFG_OFS_ALRBASE, NPIN);
  endfunction : wrOk

  // axi4-lite read side: one-cycle answer after address is taken
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // read decode: unmapped words answer with an error and zero data
  always_comb begin
    rdAddr = wordAddr(s_axi_araddr);
    rdWord = '0;
    rdOk   = 1'b1;
    if (rdAddr == `MFG_OFS_GLOBAL) begin
      rdWord[`MFG_GLB_V18]  = v18_r;
      rdWord[`MFG_GLB_DONE] = done_r;
    end else if (rdAddr == `MFG_OFS_STATUS) begin
      // live sources: a pulse between two reads only shows in sticky
      rdWord[NSTK-1:0] = {alarmEvt, lockLost};
    end else if (rdAddr == `MFG_OFS_STICKY) begin
      rdWord[NSTK-1:0] = sticky_r;
    end else if (rdAddr == `MFG_OFS_INLVL) begin
      rdWord[NPIN-1:0] = inLvl_r;
    end else if (rdAddr == `MFG_OFS_OUTLVL) begin
      rdWord[NPIN-1:0] = outLvl_r;
    end else if (rdAddr == `MFG_OFS_CLKDIS) begin
      rdWord[NCLK-1:0] = clkDis_r;
    end else begin
      rdOk = 1'b0;
      for (int p = 0; p < NPIN; p++) begin
        if (slotHit(rdAddr, `MFG_OFS_PINBASE, p)) begin
          rdWord = pinCfg_r[p];
          rdOk   = 1'b1;
        end
        if (slotHit(rdAddr, `MFG_OFS_MASKBASE, p)) begin
          rdWord[NCLK-1:0] = clkMask_r[p];
          rdOk             = 1'b1;
        end
        if (slotHit(rdAddr, `MFG_OFS_ALRBASE, p)) begin
          rdWord[NSTK-1:0] = alrEn_r[p];
          rdOk             = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rValid_r <= 1'b0;
      rData_r  <= '0;
      rResp_r  <= `MFG_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && !rValid_r) begin
        rValid_r <= 1'b1;
        rData_r  <= rdWord;
        rResp_r  <= rdOk ? `MFG_RESP_OKAY : `MFG_RESP_SLVERR;
      end else if (rValid_r && s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

endmodule : mfg_gpio

// [inc/mfg_params.svh]
/*
  constants for the multi-function pin block: register byte offsets,
  field positions, reset values and response codes.
  assumes a 32-bit axi4-lite slave with word-aligned registers.
*/
// Functional notes
// - pin functions act only once the device reset sequence has completed
// - every pin configures independently to any function and target
// - input mode samples the pin and shows its level in a status register
// - input mode is every pin's default after reset
// - output mode drives the pin from a software-written register bit
// - identically configured pins show identical outputs from shared sources
// - loss-of-lock mode drives high while the latched lock-loss bit is set
// - loss-of-lock stays set until software clears it via sticky-clear
// - alert mode outputs the OR of this pin's enabled alarm bits
// - only latched sticky bits feed the alert output
// - alert drops only after every contributing sticky bit is cleared
// - high on a disable pin disables then tri-states selected outputs
// - low on a disable pin lets selected outputs drive as configured
// - each disable pin has its own programmable output-clock mask
// - each pin has its own register enable
// - a per-pin bit selects open-drain or push-pull output drive
// - open-drain drives only low and releases the pin for high
// - push-pull drives the pin both high and low
// - a per-pin bit selects pull-up or pull-down, pull-up after reset
`ifndef MFG_PARAMS_SVH
`define MFG_PARAMS_SVH

`define MFG_OFS_GLOBAL   8'h00
`define MFG_OFS_STATUS   8'h04
`define MFG_OFS_STICKY   8'h08
`define MFG_OFS_INLVL    8'h0C
`define MFG_OFS_OUTLVL   8'h10
`define MFG_OFS_CLKDIS   8'h14
`define MFG_OFS_PINBASE  8'h40
`define MFG_OFS_MASKBASE 8'h80
`define MFG_OFS_ALRBASE  8'hC0

// per-pin config word fields
`define MFG_CFG_MODE_LO  0
`define MFG_CFG_MODE_W   3
`define MFG_CFG_EN       4
`define MFG_CFG_OD       5
`define MFG_CFG_PULLUP   6
`define MFG_CFG_RST      32'h0000_0040

// global word: bit 0 marks 1.8V supply, bit 1 reset sequence done (ro)
`define MFG_GLB_V18      0
`define MFG_GLB_DONE     1

// sticky bit positions
`define MFG_STK_LOL      0

`define MFG_RESP_OKAY    2'b00
`define MFG_RESP_SLVERR  2'b10

`endif

// [inc/mfg_pkg.sv]
/*
  types for the multi-function pin block.
  assumes mfg_params.svh supplies numeric constants.
*/
package mfg_pkg;
  typedef enum logic [2:0] {
    MFG_MODE_IN,
    MFG_MODE_OUT,
    MFG_MODE_LOL,
    MFG_MODE_ALERT,
    MFG_MODE_ODIS
  } mfg_mode_t;
endpackage : mfg_pkg

// [test/mfg_gpio_assertions.sv]
/*
  concurrent checks on the pin block top-level ports.
  assumes the top module is mfg_gpio with ports as declared.
*/
`timescale 1ns/100ps
module mfg_gpio_chk #(
  parameter int NPIN = 9,
  parameter int NCLK = 12
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic            clkEn,
  input wire logic            resetDone,
  input wire logic [NPIN-1:0] pinOe_n,
  input wire logic [NPIN-1:0] pinPullUp,
  input wire logic [NPIN-1:0] pinPullDn,
  input wire logic [NCLK-1:0] clkOutDisable,
  input wire logic [NCLK-1:0] clkOutHiZ,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clkEn;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready && clkEn;
  endsequence
  // hiz only ever inside a disable, so disable leads and trails it
  chk_hiz_subset: assert property ((clkOutHiZ & ~clkOutDisable) == '0)
    else $error("output tri-stated while not disabled");
  chk_hiz_after: assert property ($rose(|clkOutHiZ) |-> $past(|clkOutDisable))
    else $error("tri-state came before disable");
  chk_hold_off: assert property ((!resetDone && clkEn) [*2] |=> &pinOe_n)
    else $error("pin driven before reset sequence done");
  chk_pull_excl: assert property ((pinPullUp ^ pinPullDn) == '1)
    else $error("pull bias not exactly one of up or down");
  chk_wr_resp: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rd_resp: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
endmodule : mfg_gpio_chk

bind mfg_gpio mfg_gpio_chk #(.NPIN(NPIN), .NCLK(NCLK)) mfg_gpio_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .resetDone(resetDone),
  .pinOe_n(pinOe_n), .pinPullUp(pinPullUp), .pinPullDn(pinPullDn),
  .clkOutDisable(clkOutDisable), .clkOutHiZ(clkOutHiZ),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));

// [test/mfg_board_model.sv]
/*
  board side of the pins: resolves each pin wire.
  assumes oe_n low means the block drives; bias pulls a released pin.
*/
`timescale 1ns/100ps
module mfg_board_model #(
  parameter int NPIN = 9
) (
  input  wire logic [NPIN-1:0] pinOut,
  input  wire logic [NPIN-1:0] pinOe_n,
  input  wire logic [NPIN-1:0] pinPullUp,
  input  wire logic [NPIN-1:0] drvVal,
  input  wire logic [NPIN-1:0] drvEn,
  output logic      [NPIN-1:0] pinLvl
);
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (!pinOe_n[p])
        pinLvl[p] = pinOut[p];
      else if (drvEn[p])
        pinLvl[p] = drvVal[p];
      else
        pinLvl[p] = pinPullUp[p];
    end
  end
endmodule : mfg_board_model

// [test/tb.sv]
/*
  self-checking bench for the pin block.
  assumes one 125 MHz clock and a pin-side board model.
*/
`timescale 1ns/100ps
`include "mfg_params.svh"
module tb;
  logic        ref_clk = 0, rst_n = 0, clkEn = 1, resetDone = 0;
  logic        lockLost = 0;
  logic [7:0]  alarmEvt = '0, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [8:0]  pinIn, pinOut, pinOe_n, pinPullUp, pinPullDn;
  logic [8:0]  drvVal = '0, drvEn = 9'h042;
  logic [11:0] clkOutDisable, clkOutHiZ;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          errors = 0, checks = 0;

  always #4 ref_clk = ~ref_clk;

  mfg_gpio mfg_gpio_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .resetDone(resetDone), .lockLost(lockLost), .alarmEvt(alarmEvt),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pinPullUp(pinPullUp), .pinPullDn(pinPullDn),
    .clkOutDisable(clkOutDisable), .clkOutHiZ(clkOutHiZ),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  mfg_board_model mfg_board_model_inst (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .pinPullUp(pinPullUp), .drvVal(drvVal), .drvEn(drvEn), .pinLvl(pinIn));

  task automatic finish_test;
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // address and data both offered at once; each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw, w;
    @(posedge ref_clk);
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      errors++;
      finish_test;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      errors++;
      finish_test;
    end
  endtask : rd

  task automatic t_reset;
    chk(pinOe_n, 9'h1FF);
    chk(pinPullUp, 9'h1FF);
    rd(`MFG_OFS_PINBASE, d, r);
    chk(d, 32'h0000_0040);
  endtask : t_reset

  task automatic t_out;
    wr(`MFG_OFS_PINBASE, 32'h0000_0011);
    wr(`MFG_OFS_OUTLVL, 32'h0000_0001);
    cyc(2);
    chk(pinOe_n[0], 1'b1);
    @(posedge ref_clk);
    resetDone <= 1'b1;
    cyc(3);
    chk({pinOut[0], pinOe_n[0]}, 2'b10);
    wr(`MFG_OFS_OUTLVL, 32'h0000_0000);
    cyc(2);
    chk({pinOut[0], pinOe_n[0]}, 2'b00);
    wr(`MFG_OFS_PINBASE, 32'h0000_0001);
    cyc(2);
    chk(pinOe_n[0], 1'b1);
  endtask : t_out

  task automatic t_in;
    @(posedge ref_clk);
    drvVal[1] <= 1'b1;
    cyc(4);
    rd(`MFG_OFS_INLVL, d, r);
    chk(d[1], 1'b1);
  endtask : t_in

  task automatic t_od;
    wr(8'h48, 32'h0000_0071);
    cyc(2);
    chk({pinOut[2], pinOe_n[2]}, 2'b00);
    wr(`MFG_OFS_OUTLVL, 32'h0000_0004);
    cyc(2);
    chk({pinOe_n[2], pinIn[2]}, 2'b11);
    wr(8'h48, 32'h0000_0031);
    cyc(2);
    chk({pinPullDn[2], pinIn[2]}, 2'b10);
  endtask : t_od

  task automatic t_lol;
    wr(8'h4C, 32'h0000_0012);
    wr(8'h50, 32'h0000_0012);
    @(posedge ref_clk);
    lockLost <= 1'b1;
    @(posedge ref_clk);
    lockLost <= 1'b0;
    cyc(3);
    chk(pinOut[4:3], 2'b11);
    cyc(20);
    wr(`MFG_OFS_STICKY, 32'h0000_0000);
    cyc(2);
    chk(pinOut[3], 1'b1);
    wr(`MFG_OFS_STICKY, 32'h0000_0001);
    cyc(2);
    chk(pinOut[4:3], 2'b00);
  endtask : t_lol

  task automatic pulse(input logic [7:0] v);
    @(posedge ref_clk);
    alarmEvt <= v;
    @(posedge ref_clk);
    alarmEvt <= 8'h00;
    cyc(3);
  endtask : pulse

  task automatic t_alert;
    wr(8'h54, 32'h0000_0013);
    wr(8'hD4, 32'h0000_0006);
    pulse(8'h04);
    chk(pinOut[5], 1'b0);
    pulse(8'h03);
    chk(pinOut[5], 1'b1);
    wr(`MFG_OFS_STICKY, 32'h0000_0002);
    cyc(2);
    chk(pinOut[5], 1'b1);
    wr(`MFG_OFS_STICKY, 32'h0000_000C);
    cyc(2);
    chk(pinOut[5], 1'b0);
  endtask : t_alert

  task automatic t_odis;
    wr(8'h98, 32'h0000_0005);
    wr(8'h58, 32'h0000_0014);
    @(posedge ref_clk);
    drvVal[6] <= 1'b1;
    cyc(5);
    chk({clkOutDisable, clkOutHiZ}, 24'h00_5005);
    drvVal[6] <= 1'b0;
    cyc(5);
    chk({clkOutDisable, clkOutHiZ}, 24'h00_0000);
    clkEn <= 1'b0;
    drvVal[6] <= 1'b1;
    cyc(5);
    chk(clkOutDisable, 12'h000);
    clkEn <= 1'b1;
    cyc(5);
    chk(clkOutDisable, 12'h005);
    drvVal[6] <= 1'b0;
    cyc(5);
  endtask : t_odis

  task automatic t_regs;
    wr(`MFG_OFS_GLOBAL, 32'h0000_0001);
    chk(r, `MFG_RESP_OKAY);
    rd(`MFG_OFS_GLOBAL, d, r);
    chk(d, 32'h0000_0003);
    chk(r, `MFG_RESP_OKAY);
    rd(8'h20, d, r);
    chk(d, 32'h0000_0000);
    chk(r, `MFG_RESP_SLVERR);
    wr(8'h20, 32'h0000_0001);
    chk(r, `MFG_RESP_SLVERR);
  endtask : t_regs

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_out;
    t_in;
    t_od;
    t_lol;
    t_alert;
    t_odis;
    t_regs;
    finish_test;
  end
endmodule : tb
